// [include/jlsc_cfg.svh]
// offsets, field positions, reset values and counts of the link status bank
// assumes inclusion by bare name from the package; the bank uses its macros without including it
`ifndef JLSC_CFG_SVH
`define JLSC_CFG_SVH
`define JLSC_OFS_COMMA     12'h207
`define JLSC_OFS_STATUS    12'h208
`define JLSC_OFS_CHAN      12'h209
`define JLSC_OFS_SWMODE    12'h20f
`define JLSC_OFS_THRESH    12'h210
`define JLSC_RST_COMMA     8'h00
`define JLSC_RST_CHAN      8'h03
`define JLSC_RST_SWMODE    8'h00
`define JLSC_RST_THRESH    5'h03
`define JLSC_ST_LINK       6
`define JLSC_ST_SYNC       5
`define JLSC_ST_REALIGN    4
`define JLSC_ST_PHASE      3
`define JLSC_ST_SPLL       2
`define JLSC_ST_CPLL       0
`define JLSC_CH_FIRST      0
`define JLSC_CH_SECOND     1
`define JLSC_CH_SINGLE     2
`define JLSC_K28_7         8'hfc
`define JLSC_K28_1         8'h3c
`define JLSC_K28_5         8'hbc
`define JLSC_MF_PERIOD     8'h20
`endif

// [include/jlsc_pkg.sv]
// types shared by the link status bank and its surroundings
// assumes jlsc_cfg.svh on the include path
package jlsc_pkg;
	`include "jlsc_cfg.svh"

	typedef struct packed {
		logic        wr;
		logic        rd;
		logic [11:0] addr;
		logic [7:0]  wdata;
	} jlsc_req_t;

	typedef struct packed {
		logic ch_a;
		logic ch_b;
		logic ch_c;
		logic ch_d;
		logic cd_in_ab_slots;
		logic tail_pad;
	} jlsc_chan_t;

	typedef enum logic [2:0] {
		JLSC_OFF  = 3'h1,
		JLSC_SYNC = 3'h2,
		JLSC_UP   = 3'h4
	} jlsc_link_t;
endpackage

// [hw/jlsc_regs.sv]
// link status, comma select and channel enable bank of a serial transmitter
// assumes a single-cycle register port on core_clk; pins arrive asynchronous
`timescale 1ns/1ps

module jlsc_regs #(
	parameter int LW = 4,
	parameter int MW = 5
) (
	// clock and reset
	input  wire logic                 core_clk,
	input  wire logic                 rst,
	// register port
	input  wire jlsc_pkg::jlsc_req_t  req,
	output logic [7:0]                rdata,
	output logic                      rvalid,
	// pins from the far side and the analog
	input  wire logic                 sync_n,
	input  wire logic                 sysref,
	input  wire logic                 serializer_pll_lock,
	input  wire logic                 converter_pll_lock,
	// link control from the mode logic
	input  wire logic                 serial_link_enable,
	input  wire logic                 mode_8b10b,
	input  wire logic                 frame_end_slot,
	input  wire logic [LW-1:0]        lanes_full,
	input  wire logic [MW-1:0]        conv_full,
	// outputs to the framer
	output logic [7:0]                frame_end_char,
	output logic                      frame_end_insert,
	output logic                      sync_request,
	output logic                      link_up,
	output logic [LW-1:0]             lanes_used,
	output logic [MW-1:0]             conv_used,
	output jlsc_pkg::jlsc_chan_t      chan,
	output logic [7:0]                sync_word_mode
);
	import jlsc_pkg::*;

	function automatic logic [7:0] comma_code(input logic [1:0] sel);
		case (sel)
			2'h1:    comma_code = `JLSC_K28_1;
			2'h2:    comma_code = `JLSC_K28_5;
			default: comma_code = `JLSC_K28_7;
		endcase
	endfunction

	// pin synchronisers
	logic [3:0] s1_r;
	logic [3:0] s2_r;
	logic [3:0] s1_nxt;
	logic [3:0] s2_nxt;
	logic       sync_n_s;
	logic       sysref_s;
	logic       spll_s;
	logic       cpll_s;

	always_comb begin
		s1_nxt = {sync_n, sysref, serializer_pll_lock, converter_pll_lock};
		s2_nxt = s1_r;
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			s1_r <= 4'h8;
			s2_r <= 4'h8;
		end else begin
			s1_r <= s1_nxt;
			s2_r <= s2_nxt;
		end
	end

	assign sync_n_s = s2_r[3];
	assign sysref_s = s2_r[2];
	assign spll_s   = s2_r[1];
	assign cpll_s   = s2_r[0];

	// software registers
	logic [7:0] comma_r;
	logic [7:0] chan_r;
	logic [7:0] swmode_r;
	logic [4:0] thresh_r;
	logic [7:0] comma_nxt;
	logic [7:0] chan_nxt;
	logic [7:0] swmode_nxt;
	logic [4:0] thresh_nxt;

	always_comb begin
		comma_nxt  = comma_r;
		chan_nxt   = chan_r;
		swmode_nxt = swmode_r;
		thresh_nxt = thresh_r;
		if (req.wr) begin
			case (req.addr)
				`JLSC_OFS_COMMA:  comma_nxt = req.wdata;
				`JLSC_OFS_CHAN:   chan_nxt = req.wdata;
				`JLSC_OFS_SWMODE: swmode_nxt = req.wdata;
				`JLSC_OFS_THRESH: thresh_nxt = req.wdata[4:0];
				default: ;
			endcase
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			comma_r  <= `JLSC_RST_COMMA;
			chan_r   <= `JLSC_RST_CHAN;
			swmode_r <= `JLSC_RST_SWMODE;
			thresh_r <= `JLSC_RST_THRESH;
		end else begin
			comma_r  <= comma_nxt;
			chan_r   <= chan_nxt;
			swmode_r <= swmode_nxt;
			thresh_r <= thresh_nxt;
		end
	end

	// sync low counter
	logic [5:0] low_cnt_r;
	logic [5:0] low_cnt_nxt;
	logic       sync_req_r;
	logic       sync_req_nxt;

	always_comb begin
		low_cnt_nxt  = low_cnt_r;
		sync_req_nxt = 1'b0;
		if (sync_n_s) begin
			low_cnt_nxt = 6'h00;
		end else if (low_cnt_r <= {1'b0, thresh_r}) begin
			low_cnt_nxt = low_cnt_r + 6'h01;
			// shorter lows are error reports and fall away
			sync_req_nxt = (low_cnt_r == {1'b0, thresh_r});
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			low_cnt_r  <= 6'h00;
			sync_req_r <= 1'b0;
		end else begin
			low_cnt_r  <= low_cnt_nxt;
			sync_req_r <= sync_req_nxt;
		end
	end

	assign sync_request = sync_req_r;

	// sysref edge and multiframe phase
	logic       sysref_d_r;
	logic [7:0] mf_cnt_r;
	logic       en_d_r;
	logic       armed_r;
	logic       realign_r;
	logic       phase_r;
	logic       sysref_d_nxt;
	logic [7:0] mf_cnt_nxt;
	logic       en_d_nxt;
	logic       armed_nxt;
	logic       realign_nxt;
	logic       phase_nxt;
	logic       sysref_ev;
	logic       clr_wr;

	always_comb begin
		sysref_ev    = sysref_s & ~sysref_d_r;
		clr_wr       = req.wr && (req.addr == `JLSC_OFS_STATUS);
		sysref_d_nxt = sysref_s;
		en_d_nxt     = serial_link_enable;
		mf_cnt_nxt   = (mf_cnt_r == `JLSC_MF_PERIOD - 8'h01) ? 8'h00 : mf_cnt_r + 8'h01;
		armed_nxt    = armed_r;
		realign_nxt  = realign_r;
		phase_nxt    = phase_r;
		// clears first so that a same-cycle event still sets
		if (clr_wr && req.wdata[`JLSC_ST_REALIGN])
			realign_nxt = 1'b0;
		if (clr_wr && req.wdata[`JLSC_ST_PHASE])
			phase_nxt = 1'b0;
		if (serial_link_enable && !en_d_r)
			armed_nxt = 1'b1;
		if (!serial_link_enable)
			armed_nxt = 1'b0;
		if (sysref_ev) begin
			mf_cnt_nxt = 8'h01;
			if (mf_cnt_r != 8'h00)
				realign_nxt = 1'b1;
			if (armed_r) begin
				phase_nxt = 1'b1;
				armed_nxt = 1'b0;
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			sysref_d_r <= 1'b0;
			mf_cnt_r   <= 8'h00;
			en_d_r     <= 1'b0;
			armed_r    <= 1'b0;
			realign_r  <= 1'b0;
			phase_r    <= 1'b0;
		end else begin
			sysref_d_r <= sysref_d_nxt;
			mf_cnt_r   <= mf_cnt_nxt;
			en_d_r     <= en_d_nxt;
			armed_r    <= armed_nxt;
			realign_r  <= realign_nxt;
			phase_r    <= phase_nxt;
		end
	end

	// link state
	jlsc_link_t st_r;
	jlsc_link_t st_nxt;

	always_comb begin
		st_nxt = st_r;
		case (st_r)
			JLSC_OFF:
				if (serial_link_enable)
					st_nxt = JLSC_SYNC;
			JLSC_SYNC:
				if (!serial_link_enable)
					st_nxt = JLSC_OFF;
				else if (sync_n_s && phase_r)
					st_nxt = JLSC_UP;
			JLSC_UP:
				if (!serial_link_enable)
					st_nxt = JLSC_OFF;
				else if (sync_req_r)
					st_nxt = JLSC_SYNC;
			default: st_nxt = JLSC_OFF;
		endcase
	end

	always_ff @(posedge core_clk) begin
		if (rst)
			st_r <= JLSC_OFF;
		else
			st_r <= st_nxt;
	end

	assign link_up = (st_r == JLSC_UP);

	// framer outputs
	logic [7:0]    comma_out_r;
	logic          fins_r;
	logic [LW-1:0] lanes_r;
	logic [MW-1:0] conv_r;
	jlsc_chan_t    chan_q;
	logic [7:0]    comma_out_nxt;
	logic          fins_nxt;
	logic [LW-1:0] lanes_nxt;
	logic [MW-1:0] conv_nxt;
	jlsc_chan_t    chan_d;
	logic          first_en;
	logic          second_en;
	logic          single;
	logic          halved;

	always_comb begin
		first_en  = chan_r[`JLSC_CH_FIRST];
		second_en = chan_r[`JLSC_CH_SECOND];
		single    = chan_r[`JLSC_CH_SINGLE];
		halved    = ~first_en | ~second_en | single;
		comma_out_nxt = comma_code(comma_r[1:0]);
		fins_nxt  = link_up & mode_8b10b & frame_end_slot;
		chan_d.ch_a = first_en;
		chan_d.ch_b = first_en & ~single;
		chan_d.ch_c = second_en & ~single;
		chan_d.ch_d = second_en & ~single;
		chan_d.cd_in_ab_slots = ~first_en & second_en;
		chan_d.tail_pad = halved & lanes_full[0];
		lanes_nxt = lanes_full;
		conv_nxt  = conv_full;
		if (halved) begin
			lanes_nxt = (lanes_full >> 1) + {{(LW-1){1'b0}}, lanes_full[0]};
			conv_nxt  = conv_full >> 1;
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			comma_out_r <= `JLSC_K28_7;
			fins_r  <= 1'b0;
			lanes_r <= '0;
			conv_r  <= '0;
			chan_q  <= '0;
		end else begin
			comma_out_r <= comma_out_nxt;
			fins_r  <= fins_nxt;
			lanes_r <= lanes_nxt;
			conv_r  <= conv_nxt;
			chan_q  <= chan_d;
		end
	end

	assign frame_end_char   = comma_out_r;
	assign frame_end_insert = fins_r;
	assign lanes_used       = lanes_r;
	assign conv_used        = conv_r;
	assign chan             = chan_q;
	assign sync_word_mode   = swmode_r;

	// read port
	logic [7:0] status;
	logic [7:0] rdata_r;
	logic       rvalid_r;
	logic [7:0] rdata_nxt;

	always_comb begin
		status = 8'h00;
		// live bits follow their sources, writes cannot touch them
		status[`JLSC_ST_LINK]    = link_up;
		status[`JLSC_ST_SYNC]    = sync_n_s;
		status[`JLSC_ST_REALIGN] = realign_r;
		status[`JLSC_ST_PHASE]   = phase_r;
		status[`JLSC_ST_SPLL]    = spll_s;
		status[`JLSC_ST_CPLL]    = cpll_s;
		case (req.addr)
			`JLSC_OFS_COMMA:  rdata_nxt = comma_r;
			`JLSC_OFS_STATUS: rdata_nxt = status;
			`JLSC_OFS_CHAN:   rdata_nxt = chan_r;
			`JLSC_OFS_SWMODE: rdata_nxt = swmode_r;
			`JLSC_OFS_THRESH: rdata_nxt = {3'h0, thresh_r};
			default:          rdata_nxt = 8'h00;
		endcase
		if (!req.rd)
			rdata_nxt = rdata_r;
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			rdata_r  <= 8'h00;
			rvalid_r <= 1'b0;
		end else begin
			rdata_r  <= rdata_nxt;
			rvalid_r <= req.rd;
		end
	end

	assign rdata  = rdata_r;
	assign rvalid = rvalid_r;
endmodule

// [sim/jlsc_regs_properties.sv]
// port checker for the link status bank
// assumes binding into jlsc_regs from the bench top
`timescale 1ns/1ps
module jlsc_regs_properties (
	// clock and reset
	input wire logic                 core_clk,
	input wire logic                 rst,
	// pins and link control
	input wire logic                 sync_n,
	input wire logic                 serial_link_enable,
	input wire logic                 mode_8b10b,
	input wire logic                 frame_end_slot,
	// outputs watched
	input wire logic                 frame_end_insert,
	input wire logic                 sync_request,
	input wire logic                 link_up,
	input wire jlsc_pkg::jlsc_chan_t chan
);
	import jlsc_pkg::*;
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (rst);
	sequence s_slot_open;
		link_up && mode_8b10b && frame_end_slot;
	endsequence
	a_insert_gated: assert property (frame_end_insert |-> $past(link_up && mode_8b10b && frame_end_slot))
		else $error("end of frame insert without open slot");
	a_insert_follows: assert property (s_slot_open |=> frame_end_insert)
		else $error("end of frame insert missing");
	a_link_drops: assert property (!serial_link_enable |=> !link_up)
		else $error("link up with link disabled");
	a_req_low: assert property (sync_request |-> !$past(sync_n, 3))
		else $error("sync request without low pin");
	a_req_single: assert property (sync_request |=> !sync_request)
		else $error("sync request longer than one cycle");
	a_single_mode: assert property (chan.ch_a && !chan.ch_b |-> !chan.ch_c && !chan.ch_d)
		else $error("single mode keeps other channels");
	a_pairs_follow: assert property (chan.ch_c == chan.ch_d && (!chan.ch_b || chan.ch_a))
		else $error("channel pair split");
	a_slot_move: assert property (chan.cd_in_ab_slots |-> chan.ch_c && !chan.ch_a)
		else $error("slot move with first pair on");
	a_tail_halved: assert property (chan.tail_pad |-> !(chan.ch_a && chan.ch_c))
		else $error("tail pad with both pairs on");
endmodule

// [sim/jlsc_rx_model.sv]
// receiver model holding the sync pin low for a commanded run
// assumes go pulses one cycle with lows valid
`timescale 1ns/1ps
module jlsc_rx_model (
	// clock and reset
	input  wire logic       core_clk,
	input  wire logic       rst,
	// command from the bench
	input  wire logic       go,
	input  wire logic [4:0] lows,
	// sync pin, idles high
	output logic            sync_n
);
	logic [4:0] left_r;
	logic [4:0] left_nxt;
	always_comb left_nxt = rst ? 5'h00 : go ? lows : left_r - 5'(left_r != 5'h00);
	always_ff @(posedge core_clk) left_r <= left_nxt;
	assign sync_n = (left_r == 5'h00);
endmodule

// [sim/jlsc_regs_tb.sv]
// bench for the link status bank: bus tasks, scenarios, verdict
// assumes package, checker and receiver model compiled first
`timescale 1ns/1ps
module jlsc_regs_tb;
	import jlsc_pkg::*;
	logic core_clk, rst, sysref, serializer_pll_lock, converter_pll_lock, go;
	logic serial_link_enable, mode_8b10b, frame_end_slot, sync_n, rvalid;
	logic sync_request, link_up, frame_end_insert;
	logic [4:0] lows, conv_full, conv_used;
	logic [3:0] lanes_full, lanes_used;
	logic [7:0] rdata, frame_end_char, sync_word_mode, rd_v;
	jlsc_req_t  req;
	jlsc_chan_t chan;
	int         errors, n_checks, n_req;
	jlsc_regs uut (.core_clk, .rst, .req, .rdata, .rvalid, .sync_n, .sysref,
		.serializer_pll_lock, .converter_pll_lock, .serial_link_enable, .mode_8b10b,
		.frame_end_slot, .lanes_full, .conv_full, .frame_end_char, .frame_end_insert,
		.sync_request, .link_up, .lanes_used, .conv_used, .chan, .sync_word_mode);
	jlsc_rx_model rx (.core_clk, .rst, .go, .lows, .sync_n);
	initial begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end
	always @(posedge core_clk) if (sync_request === 1'b1) n_req++;
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", n_checks, errors);
		if (errors == 0 && n_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task automatic chk(string what, logic [7:0] exp, logic [7:0] got);
		n_checks++;
		if (got !== exp) begin
			errors++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic tick(int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask
	task automatic wr(logic [11:0] a, logic [7:0] d);
		req.addr = a;
		req.wdata = d;
		req.wr = 1'b1;
		tick(1);
		req.wr = 1'b0;
		tick(1);
	endtask
	task automatic rd(logic [11:0] a);
		req.addr = a;
		req.rd = 1'b1;
		tick(1);
		req.rd = 1'b0;
		for (int i = 0; i < 4 && rvalid !== 1'b1; i++) tick(1);
		if (rvalid !== 1'b1) begin
			errors++;
			give_verdict();
		end
		rd_v = rdata;
		tick(1);
	endtask
	task automatic pulse_sysref();
		sysref = 1'b1;
		tick(3);
		sysref = 1'b0;
		tick(5);
	endtask
	task automatic run_low(logic [4:0] n);
		lows = n;
		go = 1'b1;
		tick(1);
		go = 1'b0;
		tick(4);
		rd(12'h208);
		tick(24);
	endtask
	task automatic t_reset();
		logic [11:0] a [6] = '{12'h207, 12'h208, 12'h209, 12'h20f, 12'h210, 12'h300};
		logic [7:0]  e [6] = '{8'h00, 8'h25, 8'h03, 8'h00, 8'h03, 8'h00};
		for (int i = 0; i < 6; i++) begin
			rd(a[i]);
			chk("reset value", e[i], rd_v);
		end
		wr(12'h20f, 8'h02);
		chk("sync word mode", 8'h02, sync_word_mode);
		wr(12'h210, 8'h1f);
		rd(12'h210);
		chk("threshold", 8'h1f, rd_v);
		wr(12'h210, 8'h03);
		$display("test reset done");
	endtask
	task automatic t_comma();
		logic [7:0] e [4] = '{8'hfc, 8'h3c, 8'hbc, 8'hfc};
		for (int i = 0; i < 4; i++) begin
			wr(12'h207, 8'(i)); // link held off
			chk("comma", e[i], frame_end_char);
		end
		wr(12'h207, 8'h00); // compliant choice
		$display("test comma done");
	endtask
	task automatic t_chan();
		logic [7:0] w [4] = '{8'h01, 8'h02, 8'h05, 8'h03};
		logic [7:0] e [4] = '{8'h31, 8'h0f, 8'h21, 8'h3c};
		for (int i = 0; i < 4; i++) begin
			wr(12'h209, w[i]); // link off, first pair, second pair, single, then both pairs
			tick(1);
			chk("chan", e[i], 8'(chan));
			chk("lanes", (i == 3) ? 8'h05 : 8'h03, 8'(lanes_used));
			chk("conv", (i == 3) ? 8'h08 : 8'h04, 8'(conv_used));
		end
		$display("test chan done");
	endtask
	task automatic t_link();
		serial_link_enable = 1'b1;
		tick(2);
		pulse_sysref();
		pulse_sysref();
		for (int i = 0; i < 20 && link_up !== 1'b1; i++) tick(1);
		if (link_up !== 1'b1) begin
			errors++;
			give_verdict();
		end
		rd(12'h208);
		chk("status up", 8'h7d, rd_v);
		chk("insert", 8'h01, 8'(frame_end_insert));
		mode_8b10b = 1'b0;
		tick(2);
		chk("insert off", 8'h00, 8'(frame_end_insert));
		mode_8b10b = 1'b1;
		wr(12'h208, 8'hff);
		rd(12'h208);
		chk("status w1c", 8'h65, rd_v);
		run_low(5'd3);
		chk("short low", 8'h00, 8'(n_req));
		chk("still up", 8'h01, 8'(link_up));
		run_low(5'd20);
		chk("sync low", 8'h00, rd_v & 8'h20);
		chk("long low", 8'h01, 8'(n_req));
		chk("link down", 8'h00, 8'(link_up));
		serial_link_enable = 1'b0;
		$display("test link done");
	endtask
	initial begin
		rst = 1'b1;
		req = '0;
		sysref = 1'b0;
		go = 1'b0;
		lows = 5'h00;
		serializer_pll_lock = 1'b1;
		converter_pll_lock = 1'b1;
		serial_link_enable = 1'b0;
		mode_8b10b = 1'b1;
		frame_end_slot = 1'b1;
		lanes_full = 4'h5;
		conv_full = 5'h08;
		tick(12);
		rst = 1'b0;
		t_reset();
		t_comma();
		t_chan();
		t_link();
		give_verdict();
	end
endmodule
bind jlsc_regs jlsc_regs_properties props (.core_clk, .rst, .sync_n, .serial_link_enable,
	.mode_8b10b, .frame_end_slot, .frame_end_insert, .sync_request, .link_up, .chan);
